/* verilog/mgmt_pkg.sv */
// constants, field layouts and types shared by both ends of the management link
// assumes one core clock and a logic-level request/answer link between the ends
//
// How it works
// [R1] device takes both short and extended frame formats
// [R2] regs 13 and 14 reach extended space indirectly
// [R3] clear-on-read fields return value, then clear
// [R4] latch-high holds one until read or reset
// [R5] latch-low holds zero until read; reset also loads zero
// [R6] retained fields survive a software reset
// [R7] reserved fields read as zero
// [R8] set-on-read field unwritable, goes high after read
// [R9] controller reads then rewrites unchanged fields
// [R10] rw clear-on-read field clears on read, reset
// [R11] rw field reloads its non-zero default on reset
// [R12] self-clearing bit reads one while function runs
// [R13] update fields take effect after soft reset
// [R14] write-only fields accept writes, reads undefined
// [R15] bar in field equations means logical OR
// [R16] read side effects hit only the addressed register
// [R17] register 22 low byte selects page, unpaged
package mgmt_pkg;
  // =====================================================
  // register numbers (page 0 unless noted)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_MMD_CTL = 5'h0d;
  localparam logic [4:0] REG_MMD_DATA = 5'h0e;
  localparam logic [4:0] REG_CFG = 5'h10;
  localparam logic [4:0] REG_EVT = 5'h12;
  localparam logic [4:0] REG_ERRCNT = 5'h13;
  localparam logic [4:0] REG_KEY = 5'h14;
  localparam logic [4:0] REG_PAGE = 5'h16;
  // =====================================================
  // field positions
  localparam int CTL_SRST_BIT = 15;
  localparam int CTL_LOOP_BIT = 14;
  localparam int CTL_AN_BIT = 12;
  localparam int CTL_RESTART_BIT = 9;
  localparam int STAT_FAULT_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int EVT_SEEN_BIT = 15;
  localparam int EVT_ANY_BIT = 14;
  localparam int CFG_UPD_LSB = 8;
  localparam int MMD_FUNC_LSB = 14;
  // =====================================================
  // reset values
  localparam logic AN_RST = 1'b1;
  localparam logic LOOP_RST = 1'b0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] RETAIN_RST = 8'h00;
  localparam logic [3:0] UPD_RST = 4'h0;
  localparam logic [15:0] ERRCNT_RST = 16'h0000;
  localparam logic [15:0] KEY_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // =====================================================
  // timing counts in core clocks
  localparam logic [7:0] SRST_CYCLES = 8'h10;
  localparam logic [7:0] RESTART_CYCLES = 8'h20;
  // =====================================================
  // extended space mapping of short-frame registers
  localparam logic [4:0] C45_DEVAD_VS = 5'h03;
  localparam logic [2:0] C45_MAP_TAG = 3'h4;
  localparam logic [15:0] MASK_ALL = 16'hffff;
  typedef enum logic [1:0] {
    C45_ADDR = 2'b00, C45_WRITE = 2'b01, C45_READ_INC = 2'b10, C45_READ = 2'b11
  } c45_op_t;
  typedef enum logic [1:0] {
    MMD_ADDR = 2'b00, MMD_DATA = 2'b01, MMD_DATA_INC = 2'b10, MMD_DATA_INCW = 2'b11
  } mmd_func_t;
  typedef enum logic [1:0] {
    MODE_C22 = 2'b00, MODE_C45 = 2'b01, MODE_VIA_C22 = 2'b10, MODE_RSVD = 2'b11
  } host_mode_t;
endpackage

/* verilog/mgmt_if.sv */
// management link between station controller and device register bank
// assumes both ends share clk_sys; one request in flight at a time
`timescale 1ns/10ps
interface mgmt_if;
  // =====================================================
  // request, controller to device
  logic req_valid;
  logic req_write;
  logic req_c45;
  logic [1:0] c45_op;
  logic [4:0] devad;
  logic [4:0] reg_addr;
  logic [15:0] wdata;
  // =====================================================
  // answer, device to controller
  logic resp_valid;
  logic [15:0] rdata;
  modport dev (
    input req_valid, req_write, req_c45, c45_op, devad, reg_addr, wdata,
    output resp_valid, rdata
  );
  modport host (
    output req_valid, req_write, req_c45, c45_op, devad, reg_addr, wdata,
    input resp_valid, rdata
  );
endinterface

/* verilog/mgmt_dev.sv */
// device end: management register bank with its field access behaviours
// assumes requests come from logic on clk_sys, at most one per three cycles
`timescale 1ns/10ps
module mgmt_dev (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // management link
  mgmt_if.dev m,
  // status sources
  input wire logic link_up,
  input wire logic fault_in,
  input wire logic [3:0] event_in,
  input wire logic err_pulse,
  // control outputs
  output logic loopback_en,
  output logic autoneg_en,
  output logic restart_busy,
  output logic soft_reset_busy,
  output logic [7:0] retained_cfg,
  output logic [3:0] active_mode,
  output logic [15:0] key_word
);
  // =====================================================
  // state
  logic srst_reg, srst_next, restart_reg, restart_next;
  logic [7:0] srst_cnt_reg, srst_cnt_next, rs_cnt_reg, rs_cnt_next;
  logic loop_reg, loop_next, an_reg, an_next;
  logic link_ll_reg, link_ll_next, fault_lh_reg, fault_lh_next;
  logic [3:0] ev_reg, ev_next;
  logic seen_reg, seen_next;
  logic [15:0] err_reg, err_next, key_reg, key_next;
  logic [7:0] retain_reg, retain_next, page_reg, page_next;
  logic [3:0] upd_pend_reg, upd_pend_next, upd_act_reg, upd_act_next;
  logic [1:0] mmd_func_reg, mmd_func_next;
  logic [4:0] mmd_dev_reg, mmd_dev_next;
  logic [15:0] c45_addr_reg, c45_addr_next;
  logic resp_valid_reg, resp_valid_next;
  logic [15:0] rdata_reg, rdata_next;
  // =====================================================
  // decode
  logic map_on, addr_inc, hit, wr, sel;
  logic [4:0] map_dev, tgt_reg;
  logic [7:0] tgt_page;
  logic [15:0] rd_word, err_base;
  logic rd_stat, rd_evt, rd_err;
  logic wr_ctrl, wr_cfg, wr_err, wr_key, wr_page, wr_mmd_ctl, wr_mmd_data;

  always_comb begin
    map_on = 1'b0;
    addr_inc = 1'b0;
    hit = 1'b0;
    wr = m.req_write;
    map_dev = m.devad;
    tgt_reg = m.reg_addr;
    tgt_page = page_reg;
    if (m.req_valid) begin
      if (!m.req_c45) begin
        hit = 1'b1;
        // data port of the indirect window goes out to extended space
        if (m.reg_addr == mgmt_pkg::REG_MMD_DATA && mmd_func_reg != mgmt_pkg::MMD_ADDR) begin  // [R2]
          hit = 1'b0;
          map_on = 1'b1;
          map_dev = mmd_dev_reg;
          addr_inc = (mmd_func_reg == mgmt_pkg::MMD_DATA_INC) ||
                     (mmd_func_reg == mgmt_pkg::MMD_DATA_INCW && m.req_write);
        end
      end else begin  // [R1]
        map_on = (m.c45_op != mgmt_pkg::C45_ADDR);
        wr = (m.c45_op == mgmt_pkg::C45_WRITE);
        addr_inc = (m.c45_op == mgmt_pkg::C45_READ_INC);
      end
      // short-frame registers mirror at devad 3, {tag, page, reg}
      if (map_on && map_dev == mgmt_pkg::C45_DEVAD_VS && c45_addr_reg[15:13] == mgmt_pkg::C45_MAP_TAG &&
          c45_addr_reg[4:0] != mgmt_pkg::REG_MMD_CTL && c45_addr_reg[4:0] != mgmt_pkg::REG_MMD_DATA) begin
        hit = 1'b1;
        tgt_page = c45_addr_reg[12:5];
        tgt_reg = c45_addr_reg[4:0];
      end
    end
    sel = hit && (tgt_reg == mgmt_pkg::REG_PAGE || tgt_page == 8'h00);  // [R17]
    // strobes reach only the addressed register
    rd_stat = sel && !wr && tgt_reg == mgmt_pkg::REG_STAT;  // [R16]
    rd_evt = sel && !wr && tgt_reg == mgmt_pkg::REG_EVT;
    rd_err = sel && !wr && tgt_reg == mgmt_pkg::REG_ERRCNT;
    wr_ctrl = sel && wr && tgt_reg == mgmt_pkg::REG_CTRL;
    wr_cfg = sel && wr && tgt_reg == mgmt_pkg::REG_CFG;
    wr_err = sel && wr && tgt_reg == mgmt_pkg::REG_ERRCNT;
    wr_key = sel && wr && tgt_reg == mgmt_pkg::REG_KEY;
    wr_page = sel && wr && tgt_reg == mgmt_pkg::REG_PAGE;
    wr_mmd_ctl = sel && wr && tgt_reg == mgmt_pkg::REG_MMD_CTL;
    wr_mmd_data = sel && wr && tgt_reg == mgmt_pkg::REG_MMD_DATA;
    // read mux; unlisted and reserved bits stay zero
    rd_word = 16'h0000;  // [R7]
    if (sel) begin
      case (tgt_reg)
        mgmt_pkg::REG_CTRL: begin
          rd_word[mgmt_pkg::CTL_SRST_BIT] = srst_reg;
          rd_word[mgmt_pkg::CTL_LOOP_BIT] = loop_reg;
          rd_word[mgmt_pkg::CTL_AN_BIT] = an_reg;
          rd_word[mgmt_pkg::CTL_RESTART_BIT] = restart_reg;  // [R12]
        end
        mgmt_pkg::REG_STAT: begin
          rd_word[mgmt_pkg::STAT_FAULT_BIT] = fault_lh_reg;
          rd_word[mgmt_pkg::STAT_LINK_BIT] = link_ll_reg;
        end
        mgmt_pkg::REG_MMD_CTL: begin
          rd_word[mgmt_pkg::MMD_FUNC_LSB +: 2] = mmd_func_reg;
          rd_word[4:0] = mmd_dev_reg;
        end
        mgmt_pkg::REG_MMD_DATA: rd_word = c45_addr_reg;
        mgmt_pkg::REG_CFG: rd_word = {4'h0, upd_pend_reg, retain_reg};
        mgmt_pkg::REG_EVT: begin
          rd_word[3:0] = ev_reg;
          rd_word[mgmt_pkg::EVT_SEEN_BIT] = seen_reg;
          rd_word[mgmt_pkg::EVT_ANY_BIT] = ev_reg[0] | ev_reg[1] | ev_reg[2] | ev_reg[3];  // [R15]
        end
        mgmt_pkg::REG_ERRCNT: rd_word = err_reg;
        mgmt_pkg::REG_PAGE: rd_word[7:0] = page_reg;
        // write-only key reads back as zero
        mgmt_pkg::REG_KEY: rd_word = 16'h0000;  // [R14]
        default: rd_word = 16'h0000;
      endcase
    end
    c45_addr_next = c45_addr_reg;
    if (m.req_valid && m.req_c45 && m.c45_op == mgmt_pkg::C45_ADDR) begin
      c45_addr_next = m.wdata;
    end else if (wr_mmd_data) begin  // [R2]
      c45_addr_next = m.wdata;
    end else if (addr_inc) begin
      c45_addr_next = c45_addr_reg + 16'h0001;
    end
  end

  // =====================================================
  // field next values
  always_comb begin
    srst_next = srst_reg;
    srst_cnt_next = srst_cnt_reg;
    restart_next = restart_reg;
    rs_cnt_next = rs_cnt_reg;
    loop_next = loop_reg;
    an_next = an_reg;
    retain_next = retain_reg;
    upd_pend_next = upd_pend_reg;
    upd_act_next = upd_act_reg;
    page_next = page_reg;
    key_next = key_reg;
    mmd_func_next = mmd_func_reg;
    mmd_dev_next = mmd_dev_reg;
    // source wins over a read in the same cycle
    link_ll_next = link_up & (link_ll_reg | rd_stat);  // [R5]
    fault_lh_next = fault_in | (fault_lh_reg & ~rd_stat);  // [R4]
    ev_next = event_in | (ev_reg & ~{4{rd_evt}});  // [R3]
    seen_next = seen_reg | rd_evt;  // [R8]
    err_base = wr_err ? m.wdata : (rd_err ? 16'h0000 : err_reg);  // [R10]
    err_next = err_base + {15'h0000, err_pulse};
    if (wr_ctrl) begin
      loop_next = m.wdata[mgmt_pkg::CTL_LOOP_BIT];
      an_next = m.wdata[mgmt_pkg::CTL_AN_BIT];
      // writing zero to a running function does not abort it
      if (m.wdata[mgmt_pkg::CTL_RESTART_BIT]) begin  // [R12]
        restart_next = 1'b1;
        rs_cnt_next = mgmt_pkg::RESTART_CYCLES;
      end
      if (m.wdata[mgmt_pkg::CTL_SRST_BIT]) begin
        srst_next = 1'b1;
        srst_cnt_next = mgmt_pkg::SRST_CYCLES;
      end
    end
    if (wr_cfg) begin
      retain_next = m.wdata[7:0];
      upd_pend_next = m.wdata[mgmt_pkg::CFG_UPD_LSB +: 4];  // [R13]
    end
    if (wr_key) key_next = m.wdata;  // [R14]
    if (wr_page) page_next = m.wdata[7:0];  // [R17]
    if (wr_mmd_ctl) begin
      mmd_func_next = m.wdata[mgmt_pkg::MMD_FUNC_LSB +: 2];
      mmd_dev_next = m.wdata[4:0];
    end
    if (restart_reg && !(wr_ctrl && m.wdata[mgmt_pkg::CTL_RESTART_BIT])) begin
      rs_cnt_next = rs_cnt_reg - 8'h01;
      if (rs_cnt_reg == 8'h01) restart_next = 1'b0;  // [R12]
    end
    if (srst_reg) begin
      srst_cnt_next = srst_cnt_reg - 8'h01;
      if (srst_cnt_reg == 8'h01) begin
        // software reset completes: defaults back, retained fields kept
        srst_next = 1'b0;
        loop_next = mgmt_pkg::LOOP_RST;
        an_next = mgmt_pkg::AN_RST;  // [R11]
        err_next = mgmt_pkg::ERRCNT_RST;
        key_next = mgmt_pkg::KEY_RST;
        restart_next = 1'b0;
        upd_act_next = upd_pend_reg;  // [R13]
        retain_next = retain_reg;  // [R6]
        page_next = page_reg;
      end
    end
    resp_valid_next = m.req_valid;
    rdata_next = rd_word;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      srst_reg <= 1'b0;
      srst_cnt_reg <= 8'h00;
      restart_reg <= 1'b0;
      rs_cnt_reg <= 8'h00;
      loop_reg <= mgmt_pkg::LOOP_RST;
      an_reg <= mgmt_pkg::AN_RST;  // [R11]
      link_ll_reg <= 1'b0;
      fault_lh_reg <= 1'b0;
      ev_reg <= 4'h0;
      seen_reg <= 1'b0;
      err_reg <= mgmt_pkg::ERRCNT_RST;  // [R10]
      key_reg <= mgmt_pkg::KEY_RST;
      retain_reg <= mgmt_pkg::RETAIN_RST;
      upd_pend_reg <= mgmt_pkg::UPD_RST;
      upd_act_reg <= mgmt_pkg::UPD_RST;
      page_reg <= mgmt_pkg::PAGE_RST;
      mmd_func_reg <= mgmt_pkg::MMD_ADDR;
      mmd_dev_reg <= 5'h00;
      c45_addr_reg <= mgmt_pkg::ADDR_RST;
      resp_valid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      srst_reg <= srst_next;
      srst_cnt_reg <= srst_cnt_next;
      restart_reg <= restart_next;
      rs_cnt_reg <= rs_cnt_next;
      loop_reg <= loop_next;
      an_reg <= an_next;
      link_ll_reg <= link_ll_next;
      fault_lh_reg <= fault_lh_next;
      ev_reg <= ev_next;
      seen_reg <= seen_next;
      err_reg <= err_next;
      key_reg <= key_next;
      retain_reg <= retain_next;
      upd_pend_reg <= upd_pend_next;
      upd_act_reg <= upd_act_next;
      page_reg <= page_next;
      mmd_func_reg <= mmd_func_next;
      mmd_dev_reg <= mmd_dev_next;
      c45_addr_reg <= c45_addr_next;
      resp_valid_reg <= resp_valid_next;
      rdata_reg <= rdata_next;
    end
  end

  // =====================================================
  // outputs
  assign m.resp_valid = resp_valid_reg;
  assign m.rdata = rdata_reg;
  assign loopback_en = loop_reg;
  assign autoneg_en = an_reg;
  assign restart_busy = restart_reg;
  assign soft_reset_busy = srst_reg;
  assign retained_cfg = retain_reg;
  assign active_mode = upd_act_reg;
  assign key_word = key_reg;
endmodule

/* verilog/mgmt_host.sv */
// controller end: turns one user command into paged, direct or indirect frames
// assumes the device answers every request; one command at a time
`timescale 1ns/10ps
module mgmt_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // management link
  mgmt_if.host m,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_mode,
  input wire logic [4:0] cmd_devad,
  input wire logic [7:0] cmd_page,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_mask,
  // result
  output logic done,
  output logic [15:0] done_rdata
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_PAGE = 4'h1, H_MMD_CTL_A = 4'h2, H_MMD_ADR = 4'h3, H_MMD_CTL_D = 4'h4,
    H_C45_ADR = 4'h5, H_MERGE_RD = 4'h6, H_XFER = 4'h7, H_WAIT = 4'h8, H_DONE = 4'h9
  } host_state_t;
  host_state_t st_reg, st_next, ret_reg, ret_next;
  logic [1:0] mode_reg, mode_next;
  logic wr_reg, wr_next;
  logic [4:0] dev_reg, dev_next;
  logic [7:0] page_reg, page_next;
  logic [15:0] addr_reg, addr_next, wd_reg, wd_next, mask_reg, mask_next, data_reg, data_next;
  logic rv_reg, rv_next, rw_reg, rw_next, rc_reg, rc_next, ready_reg, ready_next, done_reg, done_next;
  logic [1:0] op_reg, op_next;
  logic [4:0] rdev_reg, rdev_next, rreg_reg, rreg_next;
  logic [15:0] rwd_reg, rwd_next, out_reg, out_next;
  logic merge, final_rd;
  host_state_t after_setup;

  // =====================================================
  // sequencer
  always_comb begin
    st_next = st_reg;
    ret_next = ret_reg;
    mode_next = mode_reg;
    wr_next = wr_reg;
    dev_next = dev_reg;
    page_next = page_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    mask_next = mask_reg;
    data_next = data_reg;
    rv_next = 1'b0;
    rw_next = rw_reg;
    rc_next = rc_reg;
    op_next = op_reg;
    rdev_next = rdev_reg;
    rreg_next = rreg_reg;
    rwd_next = rwd_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    out_next = out_reg;
    // partial writes read the register first
    merge = wr_reg && mask_reg != mgmt_pkg::MASK_ALL;  // [R9]
    final_rd = st_reg == H_MERGE_RD || !wr_reg;
    after_setup = merge ? H_MERGE_RD : H_XFER;
    unique case (st_reg)
      H_IDLE: begin
        if (cmd_valid) begin
          ready_next = 1'b0;
          mode_next = cmd_mode;
          wr_next = cmd_write;
          dev_next = cmd_devad;
          page_next = cmd_page;
          addr_next = cmd_addr;
          wd_next = cmd_wdata;
          mask_next = cmd_mask;
          if (cmd_mode == mgmt_pkg::MODE_C45) st_next = H_C45_ADR;
          else if (cmd_mode == mgmt_pkg::MODE_VIA_C22) st_next = H_MMD_CTL_A;  // [R2]
          else if (cmd_addr[4:0] != mgmt_pkg::REG_PAGE) st_next = H_PAGE;  // [R17]
          else st_next = (cmd_write && cmd_mask != mgmt_pkg::MASK_ALL) ? H_MERGE_RD : H_XFER;
        end
      end
      H_WAIT: begin
        if (m.resp_valid) begin
          data_next = m.rdata;
          st_next = ret_reg;
        end
      end
      H_DONE: begin
        done_next = 1'b1;
        out_next = data_reg;
        ready_next = 1'b1;
        st_next = H_IDLE;
      end
      default: begin
        // every remaining state issues one frame and waits for its answer
        rv_next = 1'b1;
        rc_next = 1'b0;
        rw_next = 1'b1;
        rdev_next = dev_reg;
        rwd_next = 16'h0000;
        st_next = H_WAIT;
        ret_next = H_DONE;
        unique case (st_reg)
          H_PAGE: begin
            rreg_next = mgmt_pkg::REG_PAGE;
            rwd_next[7:0] = page_reg;  // [R17]
            ret_next = after_setup;
          end
          H_MMD_CTL_A, H_MMD_CTL_D: begin
            rreg_next = mgmt_pkg::REG_MMD_CTL;  // [R2]
            rwd_next[mgmt_pkg::MMD_FUNC_LSB +: 2] = (st_reg == H_MMD_CTL_A) ? mgmt_pkg::MMD_ADDR : mgmt_pkg::MMD_DATA;
            rwd_next[4:0] = dev_reg;
            ret_next = (st_reg == H_MMD_CTL_A) ? H_MMD_ADR : after_setup;
          end
          H_MMD_ADR: begin
            rreg_next = mgmt_pkg::REG_MMD_DATA;
            rwd_next = addr_reg;
            ret_next = H_MMD_CTL_D;
          end
          H_C45_ADR: begin
            rc_next = 1'b1;
            op_next = mgmt_pkg::C45_ADDR;
            rwd_next = addr_reg;
            ret_next = after_setup;
          end
          H_MERGE_RD, H_XFER: begin
            rw_next = !final_rd;
            rc_next = mode_reg == mgmt_pkg::MODE_C45;
            op_next = final_rd ? mgmt_pkg::C45_READ : mgmt_pkg::C45_WRITE;
            rreg_next = (mode_reg == mgmt_pkg::MODE_VIA_C22) ? mgmt_pkg::REG_MMD_DATA : addr_reg[4:0];
            // untouched bits go back with the value just read
            rwd_next = merge ? ((data_reg & ~mask_reg) | (wd_reg & mask_reg)) : wd_reg;  // [R9]
            ret_next = (st_reg == H_MERGE_RD) ? H_XFER : H_DONE;
          end
          default: begin
            rv_next = 1'b0;
            st_next = H_IDLE;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= H_IDLE;
      ret_reg <= H_IDLE;
      mode_reg <= mgmt_pkg::MODE_C22;
      wr_reg <= 1'b0;
      dev_reg <= 5'h00;
      page_reg <= 8'h00;
      addr_reg <= 16'h0000;
      wd_reg <= 16'h0000;
      mask_reg <= 16'h0000;
      data_reg <= 16'h0000;
      rv_reg <= 1'b0;
      rw_reg <= 1'b0;
      rc_reg <= 1'b0;
      op_reg <= mgmt_pkg::C45_ADDR;
      rdev_reg <= 5'h00;
      rreg_reg <= 5'h00;
      rwd_reg <= 16'h0000;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      out_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      ret_reg <= ret_next;
      mode_reg <= mode_next;
      wr_reg <= wr_next;
      dev_reg <= dev_next;
      page_reg <= page_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      mask_reg <= mask_next;
      data_reg <= data_next;
      rv_reg <= rv_next;
      rw_reg <= rw_next;
      rc_reg <= rc_next;
      op_reg <= op_next;
      rdev_reg <= rdev_next;
      rreg_reg <= rreg_next;
      rwd_reg <= rwd_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      out_reg <= out_next;
    end
  end

  assign m.req_valid = rv_reg;
  assign m.req_write = rw_reg;
  assign m.req_c45 = rc_reg;
  assign m.c45_op = op_reg;
  assign m.devad = rdev_reg;
  assign m.reg_addr = rreg_reg;
  assign m.wdata = rwd_reg;
  assign cmd_ready = ready_reg;
  assign done = done_reg;
  assign done_rdata = out_reg;
endmodule

/* test/mgmt_properties.sv */
// checker for the management link between controller and device
// assumes one core clock; instantiated beside the link interface
`timescale 1ns/10ps
module mgmt_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // link
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_c45,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wdata,
  input wire logic resp_valid,
  input wire logic [15:0] rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // =====================================================
  // page tracking; extended writes to the page are not followed
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic seen_reg;
  logic seen_next;
  logic rd_evt;
  logic rd_short;
  assign rd_short = req_valid && !req_c45 && !req_write;
  assign rd_evt = rd_short && reg_addr == mgmt_pkg::REG_EVT && page_reg == 8'h00;
  always_comb begin
    page_next = page_reg;
    seen_next = seen_reg | rd_evt;
    if (req_valid && !req_c45 && req_write && reg_addr == mgmt_pkg::REG_PAGE) begin
      page_next = wdata[7:0];
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      page_reg <= 8'h00;
      seen_reg <= 1'b0;
    end else begin
      page_reg <= page_next;
      seen_reg <= seen_next;
    end
  end
  // =====================================================
  // properties
  a_resp_follows_req: assert property (req_valid |=> resp_valid)
    else $error("no answer one cycle after request");
  a_resp_has_cause: assert property (resp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_req_spacing: assert property (req_valid |=> !req_valid [*2])
    else $error("requests too close");
  a_key_reads_zero: assert property (rd_short && reg_addr == mgmt_pkg::REG_KEY |=> rdata == 16'h0000)
    else $error("write-only register read nonzero");
  a_unused_reads_zero: assert property (rd_short && reg_addr == 5'h1f |=> rdata == 16'h0000)
    else $error("unused register read nonzero");
  a_evt_rsvd_zero: assert property (rd_evt |=> rdata[13:4] == 10'h000)
    else $error("unused event bits nonzero");
  a_evt_any_or: assert property (rd_evt |=> rdata[14] == |rdata[3:0])
    else $error("summary bit is not the or of events");
  a_evt_set_after: assert property (rd_evt && seen_reg |=> rdata[15])
    else $error("set-on-read bit low after read");
endmodule

/* test/test_phy_mgmt_field_access_semantics.sv */
// bench: controller and device ends joined over the management link
// assumes nothing outside; clock, reset and status sources made here
`timescale 1ns/10ps
module test_phy_mgmt_field_access_semantics;
  logic clk_sys, arst_n, cmd_valid, cmd_write, cmd_ready, done, link_up, fault_in, err_pulse;
  logic loopback_en, autoneg_en, restart_busy, soft_reset_busy;
  logic [1:0] cmd_mode;
  logic [4:0] cmd_devad;
  logic [7:0] cmd_page, retained_cfg;
  logic [3:0] event_in, active_mode;
  logic [15:0] cmd_addr, cmd_wdata, cmd_mask, done_rdata, key_word, rnd;
  logic [16:0] note, notes[$];
  int bad_count, checks_done;
  mgmt_if m ();
  mgmt_dev u_mgmt_dev (.clk_sys(clk_sys), .arst_n(arst_n), .m(m.dev), .link_up(link_up),
    .fault_in(fault_in), .event_in(event_in), .err_pulse(err_pulse), .loopback_en(loopback_en),
    .autoneg_en(autoneg_en), .restart_busy(restart_busy), .soft_reset_busy(soft_reset_busy),
    .retained_cfg(retained_cfg), .active_mode(active_mode), .key_word(key_word));
  mgmt_host u_mgmt_host (.clk_sys(clk_sys), .arst_n(arst_n), .m(m.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_mode(cmd_mode), .cmd_devad(cmd_devad),
    .cmd_page(cmd_page), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_mask(cmd_mask),
    .done(done), .done_rdata(done_rdata));
  mgmt_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(m.req_valid),
    .req_write(m.req_write), .req_c45(m.req_c45), .reg_addr(m.reg_addr), .wdata(m.wdata),
    .resp_valid(m.resp_valid), .rdata(m.rdata));
  // =====================================================
  // tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (exp !== got) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic cmd(input logic w, logic [1:0] md, logic [15:0] ad, wd, mk, logic c, logic [15:0] ex);
    int n = 0;
    notes.push_back({c, ex});
    @(posedge clk_sys);
    {cmd_valid, cmd_write, cmd_mode, cmd_addr, cmd_wdata, cmd_mask} <= {1'b1, w, md, ad, wd, mk};
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100) chk("done wait", 16'h0001, 16'h0000);
  endtask
  task automatic rd(input logic [1:0] md, input logic [15:0] ad, ex);
    cmd(1'b0, md, ad, 16'h0000, 16'hffff, 1'b1, ex);
  endtask
  task automatic wr(input logic [15:0] ad, wd, mk);
    cmd(1'b1, 2'b00, ad, wd, mk, 1'b0, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // =====================================================
  // clock, result watcher, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (done === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[16]) chk("done_rdata", note[15:0], done_rdata);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
  // =====================================================
  // scenarios
  initial begin
    arst_n = 1'b0;
    {cmd_valid, cmd_write, cmd_mode, cmd_addr, cmd_wdata, cmd_mask} = '0;
    {cmd_devad, cmd_page, link_up, fault_in, event_in, err_pulse} = {5'h03, 8'h00, 1'b1, 1'b0, 4'h0, 1'b0};
    bad_count = 0;
    checks_done = 0;
    rnd = 16'($urandom(32'h7c0f1295));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk("autoneg_en", 16'h0001, {15'h0, autoneg_en});
    wr(16'h0010, 16'h0a5c, 16'hffff);
    rd(2'b00, 16'h0010, 16'h0a5c);
    rd(2'b01, 16'h8010, 16'h0a5c);
    rd(2'b10, 16'h8010, 16'h0a5c);
    chk("active_mode", 16'h0000, {12'h0, active_mode});
    wr(16'h0000, 16'h4000, 16'h4000);
    chk("loopback_en", 16'h0001, {15'h0, loopback_en});
    chk("autoneg_en", 16'h0001, {15'h0, autoneg_en});
    wr(16'h0000, 16'h0200, 16'h0200);
    chk("restart_busy", 16'h0001, {15'h0, restart_busy});
    wr(16'h0000, 16'h8000, 16'h8000);
    chk("soft_reset_busy", 16'h0001, {15'h0, soft_reset_busy});
    repeat (20) @(posedge clk_sys);
    chk("soft_reset_busy", 16'h0000, {15'h0, soft_reset_busy});
    chk("restart_busy", 16'h0000, {15'h0, restart_busy});
    chk("loopback_en", 16'h0000, {15'h0, loopback_en});
    chk("retained_cfg", 16'h005c, {8'h0, retained_cfg});
    chk("active_mode", 16'h000a, {12'h0, active_mode});
    cmd(1'b1, 2'b01, 16'h8010, 16'h0033, 16'h00ff, 1'b0, 16'h0000);
    rd(2'b10, 16'h8010, 16'h0a33);
    {fault_in, link_up} <= 2'b10;
    @(posedge clk_sys);
    {fault_in, link_up} <= 2'b01;
    rd(2'b00, 16'h0001, 16'h0010);
    rd(2'b00, 16'h0001, 16'h0004);
    event_in <= 4'h5;
    @(posedge clk_sys);
    event_in <= 4'h0;
    rd(2'b00, 16'h0012, 16'h4005);
    rd(2'b00, 16'h0012, 16'h8000);
    err_pulse <= 1'b1;
    repeat (3) @(posedge clk_sys);
    err_pulse <= 1'b0;
    rd(2'b00, 16'h0001, 16'h0004);
    rd(2'b00, 16'h0013, 16'h0003);
    rd(2'b00, 16'h0013, 16'h0000);
    rnd = 16'($urandom());
    wr(16'h0013, rnd, 16'hffff);
    rd(2'b00, 16'h0013, rnd);
    rnd = 16'($urandom());
    wr(16'h0014, rnd, 16'hffff);
    chk("key_word", rnd, key_word);
    rd(2'b00, 16'h0014, 16'h0000);
    rd(2'b00, 16'h001f, 16'h0000);
    cmd_page <= 8'h01;
    rd(2'b00, 16'h0010, 16'h0000);
    rd(2'b00, 16'h0016, 16'h0001);
    @(posedge clk_sys);
    print_verdict();
  end
endmodule
